/* wiper_host_model.sv */
// Host controller model: frames commands on the serial link and collects readback bits.
// Assumes the bench clock is 50 MHz; all pins change on its falling edge.
`timescale 1ns/1ps
module wiper_host_model (
    input wire logic i_clk,
    input wire logic i_ready,
    input wire logic i_data_out,
    output logic o_sync_n,
    output logic o_sclk,
    output logic o_din
);
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        o_sync_n = 1'b1;
        o_sclk = 1'b0;
        o_din = 1'b0;
    end

    task automatic idle(input int n);
        repeat (n) @(negedge i_clk);
    endtask : idle

    // Sends nb bits of w MSB first; rd holds the bits seen on the data out line
    task automatic send(input logic [15:0] w, input int nb, input bit tail,
                        output logic [15:0] rd, output bit ok);
        int k;
        rd = 16'h0000;
        k = 0;
        while (i_ready !== 1'b1 && k < 5000) begin
            idle(1);
            k++;
        end
        ok = (k < 5000);
        idle(21);
        o_sync_n = 1'b0;
        idle(8);
        for (int i = 0; i < nb; i++) begin
            rd = {rd[14:0], i_data_out};
            o_din = w[15-i];
            o_sclk = 1'b1;
            idle(4);
            o_sclk = 1'b0;
            idle(4);
        end
        o_sync_n = 1'b1;
        o_din = ~o_din;
        if (tail) begin
            o_sclk = 1'b1;
            idle(1);
            o_sclk = 1'b0;
        end
    endtask : send
endmodule : wiper_host_model

/* wiper_port_pkg.sv */
// Constants for the wiper serial command port: frame layout, command codes and execute times.
// Assumes a 50 MHz system clock; all cycle counts derive from CLK_NS.
package wiper_port_pkg;
    localparam int CLK_NS = 20;
    localparam int FRAME_BITS = 16;
    localparam int WIPER_BITS = 10;
    localparam int CMD_LSB = 10;
    localparam int CMD_BITS = 4;
    localparam int CNT_BITS = 17;
    // Longest times, rounded down to whole cycles
    localparam int WR_NORM_NS = 410;
    localparam int WR_PERF_NS = 2400;
    localparam int RD_NS = 450;
    localparam int RST_NS = 1500000;
    localparam int POWERUP_NS = 2000000;
    localparam int SYNC_ACK_NS = 40;
    localparam int WR_NORM_CYC = WR_NORM_NS / CLK_NS;
    localparam int WR_PERF_CYC = WR_PERF_NS / CLK_NS;
    localparam int RD_CYC = RD_NS / CLK_NS;
    localparam int RST_CYC = RST_NS / CLK_NS;
    localparam int POWERUP_CYC = POWERUP_NS / CLK_NS;
    localparam logic [WIPER_BITS-1:0] WIPER_MID = 10'h200;
    localparam logic [FRAME_BITS-1:0] SHIFT_RST = 16'h0000;
    localparam logic [4:0] BITS_RST = 5'h00;
    localparam logic [CMD_BITS-1:0] CMD_NOP = 4'h0;
    localparam logic [CMD_BITS-1:0] CMD_WRITE = 4'h1;
    localparam logic [CMD_BITS-1:0] CMD_READ = 4'h2;
    localparam logic [CMD_BITS-1:0] CMD_RESET = 4'h4;

    typedef enum logic [1:0] {
        KIND_NONE = 2'b00,
        KIND_WRITE = 2'b01,
        KIND_READ = 2'b10,
        KIND_RESET = 2'b11
    } kind_type;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_BUSY = 1'b1
    } state_type;
endpackage : wiper_port_pkg

/* wiper_serial_port.sv */
// Wiper serial command port: frame receiver, command executor, ready line and readback shifter.
// Assumes the link pins are asynchronous to I_CLK and the serial clock is slow enough to sample.
//
// Function
// - Performance-mode wiper write holds ready low at most 2.4 us.
// - Normal-mode wiper write releases ready within 410 ns.
// - Software or hardware reset holds ready low at most 1.5 ms.
// - Wiper read holds ready low at most 450 ns.
// - Ready goes low promptly after frame sync rises on a full frame.
// - Wiper sits at half scale after power is applied.
// - Readback data out changes after each rising serial clock edge.
// - Falling serial clock edges just after frame sync rises are ignored.
// - Data in shifts into a 16-bit register on falling clock while framed.
// - Full frame executes on sync rise; short frame is discarded.
// - Hardware reset rising transition sets the wiper to midscale.
`timescale 1ns/1ps
module wiper_serial_port #(
    parameter int RESET_CYCLES = wiper_port_pkg::RST_CYC
) (
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    input wire logic I_FRAME_SYNC_N,
    input wire logic I_SCLK,
    input wire logic I_DIN,
    input wire logic I_HW_RESET,
    input wire logic I_PERF_MODE,
    input wire logic I_READY,
    output logic O_READY,
    output logic O_READY_OE,
    output logic O_SERIAL_DATA_OUT,
    output logic [wiper_port_pkg::WIPER_BITS-1:0] O_WIPER
);

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge detection
    logic [2:0] sync_n_q;
    logic [2:0] sclk_q;
    logic [2:0] hwr_q;
    logic [1:0] din_q;
    logic [1:0] perf_q;

    function automatic logic rose(input logic prev, input logic cur);
        rose = !prev && cur;
    endfunction : rose

    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            sync_n_q <= 3'h7;
            sclk_q <= 3'h0;
            hwr_q <= 3'h0;
            din_q <= 2'h0;
            perf_q <= 2'h0;
        end else begin
            sync_n_q <= {sync_n_q[1:0], I_FRAME_SYNC_N};
            sclk_q <= {sclk_q[1:0], I_SCLK};
            hwr_q <= {hwr_q[1:0], I_HW_RESET};
            din_q <= {din_q[0], I_DIN};
            perf_q <= {perf_q[0], I_PERF_MODE};
        end
    end

    logic sync_rise;
    logic sync_fall;
    logic sclk_rise;
    logic sclk_fall;
    logic hwr_rise;
    assign sync_rise = rose(sync_n_q[2], sync_n_q[1]);
    assign sync_fall = rose(sync_n_q[1], sync_n_q[2]);
    assign sclk_rise = rose(sclk_q[2], sclk_q[1]);
    assign sclk_fall = rose(sclk_q[1], sclk_q[2]);
    assign hwr_rise = rose(hwr_q[2], hwr_q[1]);

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Frame receiver
    logic frame_q;
    logic frame_d;
    logic [wiper_port_pkg::FRAME_BITS-1:0] shift_q;
    logic [wiper_port_pkg::FRAME_BITS-1:0] shift_d;
    logic [4:0] bits_q;
    logic [4:0] bits_d;
    wiper_port_pkg::state_type state_q;
    wiper_port_pkg::state_type state_d;
    logic full_frame;
    logic [wiper_port_pkg::CMD_BITS-1:0] cmd;

    assign full_frame = bits_q >= 5'(wiper_port_pkg::FRAME_BITS);
    assign cmd = shift_q[wiper_port_pkg::CMD_LSB +: wiper_port_pkg::CMD_BITS];

    always_comb begin
        frame_d = frame_q;
        shift_d = shift_q;
        bits_d = bits_q;
        if (sync_fall && state_q == wiper_port_pkg::ST_IDLE) begin
            frame_d = 1'b1;
            bits_d = wiper_port_pkg::BITS_RST;
        end else if (sync_rise) begin
            frame_d = 1'b0;
        end else if (frame_q && sclk_fall) begin
            shift_d = {shift_q[wiper_port_pkg::FRAME_BITS-2:0], din_q[1]};
            if (!full_frame) begin
                bits_d = bits_q + 5'h01;
            end
        end
    end

    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            frame_q <= 1'b0;
            shift_q <= wiper_port_pkg::SHIFT_RST;
            bits_q <= wiper_port_pkg::BITS_RST;
        end else begin
            frame_q <= frame_d;
            shift_q <= shift_d;
            bits_q <= bits_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Command executor and ready line
    logic [wiper_port_pkg::CNT_BITS-1:0] cnt_q;
    logic [wiper_port_pkg::CNT_BITS-1:0] cnt_d;
    logic [wiper_port_pkg::WIPER_BITS-1:0] wiper_q;
    logic [wiper_port_pkg::WIPER_BITS-1:0] wiper_d;
    wiper_port_pkg::kind_type kind_q;
    wiper_port_pkg::kind_type kind_d;
    logic perf_run_q;
    logic perf_run_d;
    logic oe_q;
    logic load_read;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        wiper_d = wiper_q;
        kind_d = kind_q;
        perf_run_d = perf_run_q;
        load_read = 1'b0;
        case (state_q)
            wiper_port_pkg::ST_IDLE: begin
                if (hwr_rise) begin
                    wiper_d = wiper_port_pkg::WIPER_MID;
                    state_d = wiper_port_pkg::ST_BUSY;
                    kind_d = wiper_port_pkg::KIND_RESET;
                    cnt_d = wiper_port_pkg::CNT_BITS'(RESET_CYCLES - 1);
                end else if (sync_rise && frame_q && full_frame) begin
                    state_d = wiper_port_pkg::ST_BUSY;
                    if (cmd == wiper_port_pkg::CMD_WRITE) begin
                        wiper_d = shift_q[wiper_port_pkg::WIPER_BITS-1:0];
                        kind_d = wiper_port_pkg::KIND_WRITE;
                        perf_run_d = perf_q[1];
                        if (perf_q[1]) begin
                            cnt_d = wiper_port_pkg::CNT_BITS'(wiper_port_pkg::WR_PERF_CYC - 1);
                        end else begin
                            cnt_d = wiper_port_pkg::CNT_BITS'(wiper_port_pkg::WR_NORM_CYC - 1);
                        end
                    end else if (cmd == wiper_port_pkg::CMD_READ) begin
                        load_read = 1'b1;
                        kind_d = wiper_port_pkg::KIND_READ;
                        cnt_d = wiper_port_pkg::CNT_BITS'(wiper_port_pkg::RD_CYC - 1);
                    end else if (cmd == wiper_port_pkg::CMD_RESET) begin
                        wiper_d = wiper_port_pkg::WIPER_MID;
                        kind_d = wiper_port_pkg::KIND_RESET;
                        cnt_d = wiper_port_pkg::CNT_BITS'(RESET_CYCLES - 1);
                    end else begin
                        kind_d = wiper_port_pkg::KIND_NONE;
                        cnt_d = wiper_port_pkg::CNT_BITS'(0);
                    end
                end
            end
            wiper_port_pkg::ST_BUSY: begin
                if (hwr_rise) begin
                    wiper_d = wiper_port_pkg::WIPER_MID;
                    kind_d = wiper_port_pkg::KIND_RESET;
                    cnt_d = wiper_port_pkg::CNT_BITS'(RESET_CYCLES - 1);
                end else if (cnt_q == '0) begin
                    state_d = wiper_port_pkg::ST_IDLE;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            default: begin
                state_d = wiper_port_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            state_q <= wiper_port_pkg::ST_IDLE;
            cnt_q <= '0;
            wiper_q <= wiper_port_pkg::WIPER_MID;
            kind_q <= wiper_port_pkg::KIND_NONE;
            perf_run_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            wiper_q <= wiper_d;
            kind_q <= kind_d;
            perf_run_q <= perf_run_d;
            oe_q <= state_d == wiper_port_pkg::ST_BUSY;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Readback shifter
    logic [wiper_port_pkg::FRAME_BITS-1:0] out_q;
    logic [wiper_port_pkg::FRAME_BITS-1:0] out_d;
    logic sdo_q;
    logic sdo_d;

    always_comb begin
        out_d = out_q;
        sdo_d = sdo_q;
        if (load_read) begin
            out_d = {6'h00, wiper_q};
        end else if (sync_fall && state_q == wiper_port_pkg::ST_IDLE) begin
            sdo_d = out_q[wiper_port_pkg::FRAME_BITS-1];
        end else if (frame_q && sclk_rise) begin
            out_d = {out_q[wiper_port_pkg::FRAME_BITS-2:0], 1'b0};
            sdo_d = out_q[wiper_port_pkg::FRAME_BITS-2];
        end
    end

    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            out_q <= wiper_port_pkg::SHIFT_RST;
            sdo_q <= 1'b0;
        end else begin
            out_q <= out_d;
            sdo_q <= sdo_d;
        end
    end

    assign O_READY = 1'b0 & oe_q;
    assign O_READY_OE = oe_q;
    assign O_SERIAL_DATA_OUT = sdo_q;
    assign O_WIPER = wiper_q;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Checks
    logic [wiper_port_pkg::CNT_BITS-1:0] low_len_q;
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            low_len_q <= '0;
        end else begin
            low_len_q <= (oe_q && !hwr_rise) ? low_len_q + 1'b1 : '0;
        end
    end

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_SYS_RST);

    write_perf_len_a: assert property (oe_q && kind_q == wiper_port_pkg::KIND_WRITE && perf_run_q
        |-> low_len_q < wiper_port_pkg::WR_PERF_CYC) else $error("perf write busy too long");
    write_norm_len_a: assert property (oe_q && kind_q == wiper_port_pkg::KIND_WRITE && !perf_run_q
        |-> low_len_q < wiper_port_pkg::WR_NORM_CYC) else $error("write busy too long");
    reset_len_a: assert property (oe_q && kind_q == wiper_port_pkg::KIND_RESET
        |-> low_len_q < RESET_CYCLES) else $error("reset busy too long");
    read_len_a: assert property (oe_q && kind_q == wiper_port_pkg::KIND_READ
        |-> low_len_q < wiper_port_pkg::RD_CYC) else $error("read busy too long");
    ready_fall_a: assert property (sync_rise && frame_q && full_frame && !oe_q
        |=> oe_q) else $error("ready not lowered after frame");
    sdo_shift_a: assert property (frame_q && sclk_rise && !sync_rise && !load_read
        |=> sdo_q == $past(out_q[14])) else $error("data out not shifted");
    din_shift_a: assert property (frame_q && sclk_fall && !sync_rise && !sync_fall
        |=> shift_q[0] == $past(din_q[1])) else $error("data in not captured");
    short_frame_a: assert property (sync_rise && !full_frame && !oe_q && !hwr_rise
        |=> $stable(wiper_q) && !oe_q) else $error("short frame acted");
    hw_reset_a: assert property (hwr_rise |=> wiper_q == wiper_port_pkg::WIPER_MID && oe_q)
        else $error("hardware reset missed");
    open_drain_a: assert property (O_READY == 1'b0 && (oe_q == (state_q == wiper_port_pkg::ST_BUSY)))
        else $error("ready drive wrong");

    write_seen_c: cover property (oe_q && kind_q == wiper_port_pkg::KIND_WRITE ##1 !oe_q);
    read_seen_c: cover property (kind_q == wiper_port_pkg::KIND_READ ##1 frame_q && sclk_rise);
    reset_seen_c: cover property (hwr_rise ##1 oe_q);

endmodule : wiper_serial_port

/* wiper_serial_port_tb.sv */
// Testbench for the wiper serial port: host model, pulled-up ready wire, behavioural wiper.
// Assumes the design's reset count parameter is set small for simulation.
`timescale 1ns/1ps
`define CHK(n, e, g) chk(n, e, g)
module wiper_serial_port_tb;
    localparam int RST_SIM = 50;
    logic I_CLK = 1'b0;
    logic I_SYS_RST = 1'b1;
    logic I_HW_RESET = 1'b0;
    logic I_PERF_MODE = 1'b0;
    logic sync_n, sclk, din, ready_wire;
    logic O_READY, O_READY_OE, O_SERIAL_DATA_OUT;
    logic [9:0] O_WIPER;
    logic [9:0] m_wiper = 10'h200;
    bit m_rd_pend = 1'b0;
    int err_count = 0;
    int n_compared = 0;
    integer seed = 67145;
    int lat, busy;

    always #10 I_CLK = ~I_CLK;
    assign ready_wire = O_READY_OE ? O_READY : 1'b1;

    wiper_serial_port #(.RESET_CYCLES(RST_SIM)) DUT (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST),
        .I_FRAME_SYNC_N(sync_n), .I_SCLK(sclk), .I_DIN(din), .I_HW_RESET(I_HW_RESET),
        .I_PERF_MODE(I_PERF_MODE), .I_READY(ready_wire), .O_READY(O_READY),
        .O_READY_OE(O_READY_OE), .O_SERIAL_DATA_OUT(O_SERIAL_DATA_OUT), .O_WIPER(O_WIPER));
    wiper_host_model host (.i_clk(I_CLK), .i_ready(ready_wire), .i_data_out(O_SERIAL_DATA_OUT),
        .o_sync_n(sync_n), .o_sclk(sclk), .o_din(din));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk

    task automatic measure();
        lat = 0;
        busy = 0;
        while (O_READY_OE !== 1'b1 && lat < 8) begin
            @(negedge I_CLK);
            lat++;
        end
        while (O_READY_OE === 1'b1 && busy < 1000) begin
            `CHK("ready_low", 16'h0000, O_READY);
            @(negedge I_CLK);
            busy++;
        end
        if (busy >= 1000) begin
            err_count++;
            disable run_all;
        end
    endtask : measure

    task automatic do_cmd(input logic [3:0] cmd, input logic [9:0] d, input logic perf,
                          input int nb, input bit tail);
        logic [15:0] rd;
        bit ok;
        int lim;
        I_PERF_MODE = perf;
        host.send({2'b00, cmd, d}, nb, tail, rd, ok);
        `CHK("ready_wait", 16'h0001, ok);
        if (!ok) begin
            disable run_all;
        end
        if (m_rd_pend) `CHK("readback", {6'h00, m_wiper}, rd);
        m_rd_pend = (nb == 16 && cmd == wiper_port_pkg::CMD_READ);
        lim = (cmd == wiper_port_pkg::CMD_WRITE) ?
              (perf ? wiper_port_pkg::WR_PERF_CYC : wiper_port_pkg::WR_NORM_CYC) :
              (cmd == wiper_port_pkg::CMD_READ) ? wiper_port_pkg::RD_CYC :
              (cmd == wiper_port_pkg::CMD_RESET) ? RST_SIM : 1;
        measure();
        if (nb == 16 && cmd == wiper_port_pkg::CMD_WRITE) m_wiper = d;
        if (nb == 16 && cmd == wiper_port_pkg::CMD_RESET) m_wiper = 10'h200;
        if (nb < 16) begin
            `CHK("short_busy", 16'h0000, busy);
        end else begin
            `CHK("start_lat", 16'h0001, lat <= 5);
            `CHK("busy_len", 16'h0001, busy > 0 && busy <= lim);
        end
        `CHK("wiper", m_wiper, O_WIPER);
    endtask : do_cmd

    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        begin : run_all
            repeat (16) @(negedge I_CLK);
            I_SYS_RST = 1'b0;
            repeat (3) @(negedge I_CLK);
            `CHK("wiper_init", 16'h0200, O_WIPER);
            for (int i = 0; i < 4; i++) begin
                do_cmd(wiper_port_pkg::CMD_WRITE, 10'($random(seed)), i[0], 16, i == 3);
            end
            do_cmd(wiper_port_pkg::CMD_WRITE, 10'h3ff, 1'b0, 16, 1'b0);
            do_cmd(wiper_port_pkg::CMD_READ, 10'h000, 1'b0, 16, 1'b0);
            do_cmd(wiper_port_pkg::CMD_NOP, 10'h000, 1'b0, 16, 1'b0);
            do_cmd(wiper_port_pkg::CMD_WRITE, 10'h000, 1'b0, 15, 1'b0);
            do_cmd(wiper_port_pkg::CMD_WRITE, 10'h000, 1'b1, 16, 1'b0);
            do_cmd(wiper_port_pkg::CMD_READ, 10'h000, 1'b0, 16, 1'b0);
            do_cmd(4'h7, 10'h2aa, 1'b0, 16, 1'b0);
            do_cmd(wiper_port_pkg::CMD_RESET, 10'h000, 1'b0, 16, 1'b0);
            do_cmd(wiper_port_pkg::CMD_WRITE, 10'h155, 1'b0, 16, 1'b0);
            I_HW_RESET = 1'b1;
            repeat (2) @(negedge I_CLK);
            I_HW_RESET = 1'b0;
            m_wiper = 10'h200;
            measure();
            `CHK("hw_busy", 16'h0001, busy > 0 && busy <= RST_SIM);
            `CHK("hw_wiper", m_wiper, O_WIPER);
            do_cmd(wiper_port_pkg::CMD_READ, 10'h000, 1'b1, 16, 1'b0);
            do_cmd(wiper_port_pkg::CMD_NOP, 10'h000, 1'b0, 16, 1'b0);
        end
        report_and_stop();
    end
endmodule : wiper_serial_port_tb
